// ### rtl/spi_err_pkg.sv
// Shared constants for the serial interface error and control block.
// Assumes an 8-bit register port and a single 250 MHz core clock.
package spi_err_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_PORT_DATA = 8'h08;
  localparam logic [7:0] OFS_PORT_DIR  = 8'h09;
  localparam logic [7:0] OFS_CONTROL   = 8'h28;
  localparam logic [7:0] OFS_STATUS    = 8'h29;
  localparam logic [7:0] OFS_DATA      = 8'h2A;
  localparam logic [7:0] OFS_EVENT     = 8'h2B;
  localparam logic [7:0] OFS_EVT_MASK  = 8'h2C;
  // ==========================================================
  // Control register fields
  localparam int CTL_IRQ_EN   = 7;
  localparam int CTL_SYS_EN   = 6;
  localparam int CTL_OPEN_DRN = 5;
  localparam int CTL_MASTER   = 4;
  localparam int CTL_CLOCK_IDLE_POLARITY     = 3;
  localparam int CTL_CLOCK_PHASE_SELECT     = 2;
  localparam int CTL_RATE_HI  = 1;
  localparam logic [7:0] CONTROL_RESET = 8'h04;
  // ==========================================================
  // Status register fields, event bits and pin indices
  localparam int STS_COMPLETE  = 7;
  localparam int STS_COLLISION = 6;
  localparam int STS_MODE_FLT  = 4;
  localparam int EVT_COMPLETE  = 0;
  localparam int EVT_MODE_FLT  = 1;
  localparam int EVT_COLLISION = 2;
  localparam int PIN_MISO = 0;
  localparam int PIN_MOSI = 1;
  localparam int PIN_SCK  = 2;
  localparam int PIN_SS   = 3;
  localparam int PORT_LSB = 2;
  // ==========================================================
  // Master half-period in core cycles per rate setting (divide 2,4,16,32)
  localparam logic [4:0] HALF_PERIOD [4] = '{5'h01, 5'h02, 5'h08, 5'h10};
  localparam logic [3:0] LAST_EDGE      = 4'hF;
  localparam logic [3:0] LAST_EDGE_CPH0 = 4'hE;
endpackage

// ### rtl/spi_core_if.sv
// Bundle between the control block and its bit shifter.
// Assumes both ends run on ref_clk; all inputs here are already synchronised.
interface spi_core_if;
  logic       load;
  logic [7:0] txByte;
  logic       master;
  logic       clock_idle_polarity;
  logic       clock_phase_select;
  logic [1:0] rate;
  logic       sckIn;
  logic       ssLow;
  logic       sdi;
  logic       done;
  logic [7:0] rxByte;
  logic       sckOut;
  logic       sdo;
  logic       busy;
  modport ctrl (output load, txByte, master, clock_idle_polarity, clock_phase_select, rate, sckIn, ssLow, sdi,
                input  done, rxByte, sckOut, sdo, busy);
  modport eng  (input  load, txByte, master, clock_idle_polarity, clock_phase_select, rate, sckIn, ssLow, sdi,
                output done, rxByte, sckOut, sdo, busy);
endinterface

// ### rtl/pin_sync.sv
// Two-stage synchroniser for a group of pin levels.
// Assumes the inputs are asynchronous levels; outputs are on ref_clk.
module pin_sync #(
  parameter int W = 4
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] async,
  output logic      [W-1:0] sync
);
  typedef struct packed {logic [W-1:0] s1; logic [W-1:0] s2;} sync_t;
  sync_t s_q, s_d;
  // ==========================================================
  // First stage feeds only the second
  always_comb begin
    s_d    = s_q;
    s_d.s1 = async;
    s_d.s2 = s_q.s1;
  end
  always_ff @(posedge ref_clk) begin
    if (rst) s_q <= '0;
    else     s_q <= s_d;
  end
  assign sync = s_q.s2;
endmodule

// ### rtl/spi_shifter.sv
// Eight-bit serial shifter, master clock generator and slave edge finder.
// Assumes synchronised pins and a control block that gates loads.
module spi_shifter (
  input  wire logic ref_clk,
  input  wire logic rst,
  spi_core_if.eng   e
);
  typedef struct packed {
    logic active; logic [4:0] half; logic [3:0] cnt; logic sckAct;
    logic sckPrev; logic [7:0] sh; logic latch; logic [7:0] rx; logic done;
  } shift_t;
  shift_t s_q, s_d;
  logic   edgeHit;
  logic   sampleEdge;
  logic [3:0] lastEdge;
  // ==========================================================
  // Edge generation and shifting; loads go straight into the shifter [RQ5]
  always_comb begin
    s_d        = s_q;
    s_d.done   = 1'b0;
    edgeHit    = 1'b0;
    lastEdge   = (e.master || e.clock_phase_select) ? spi_err_pkg::LAST_EDGE : spi_err_pkg::LAST_EDGE_CPH0;
    sampleEdge = (s_q.cnt[0] == e.clock_phase_select);
    s_d.sckPrev = e.sckIn ^ e.clock_idle_polarity;
    if (e.master) begin
      if (e.load && !s_q.active) begin
        s_d.active = 1'b1;
        s_d.sh     = e.txByte;
        s_d.cnt    = 4'h0;
        s_d.half   = 5'h01;
        s_d.sckAct = 1'b0;
      end else if (s_q.active) begin
        if (s_q.half == spi_err_pkg::HALF_PERIOD[e.rate]) begin
          s_d.half   = 5'h01;
          edgeHit    = 1'b1;
          s_d.sckAct = ~s_q.sckAct;
        end else begin
          s_d.half = s_q.half + 5'h01;
        end
      end
    end else begin
      s_d.active = 1'b0;
      s_d.sckAct = 1'b0;
      if (e.load) s_d.sh = e.txByte;
      edgeHit = e.ssLow && (s_q.sckPrev != s_d.sckPrev);
      if (!e.ssLow && !e.clock_phase_select) s_d.cnt = 4'h0;  // Frame ends with select [RQ8]
    end
    if (edgeHit) begin
      if (sampleEdge) s_d.latch = e.sdi;
      else if (s_q.cnt != 4'h0) s_d.sh = {s_q.sh[6:0], s_q.latch};
      if (s_q.cnt != 4'hF) s_d.cnt = s_q.cnt + 4'h1;
      if (s_q.cnt == lastEdge) begin
        s_d.done = 1'b1;  // Mid eighth cycle for phase 0 slave [RQ9]
        s_d.rx   = {s_q.sh[6:0], sampleEdge ? e.sdi : s_q.latch};
        if (e.master) s_d.active = 1'b0;
        if (e.master || e.clock_phase_select) s_d.cnt = 4'h0;  // Ends at completion [RQ10]
      end
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) s_q <= '0;
    else     s_q <= s_d;
  end
  assign e.done   = s_q.done;
  assign e.rxByte = s_q.rx;
  assign e.sdo    = s_q.sh[7];
  assign e.sckOut = s_q.sckAct ^ e.clock_idle_polarity;
  // Transfer in progress per configuration [RQ7] [RQ8] [RQ10]
  assign e.busy   = e.master ? s_q.active : (e.clock_phase_select ? (s_q.cnt != 4'h0) : e.ssLow);
endmodule

// ### rtl/spi_error_and_control.sv
// Serial interface control, status, error detection and port pin steering.
// Assumes a register port on ref_clk and port pins from outside the clock domain.
//
// How it works
// [RQ1] Master seeing select low raises the mode fault flag.
// [RQ2] Mode fault clears master select and the four direction bits.
// [RQ3] Data write during a transfer raises the write collision flag.
// [RQ4] Colliding write is dropped; the running transfer is untouched.
// [RQ5] Allowed data writes load the shifter directly, no transmit buffer.
// [RQ6] Collision detection works in master and slave.
// [RQ7] Master transfer runs from data write until completion flag sets.
// [RQ8] Phase 0 slave transfer runs while select is low.
// [RQ9] Phase 0 slave completes mid eighth cycle, still in progress.
// [RQ10] Phase 1 slave transfer runs from first leading edge to completion.
// [RQ11] Control register holds enable, system, open drain, master, clocking, rate.
// [RQ12] Interrupt requests follow completion or fault, gated by enable and mask.
// [RQ13] System enable gives port pins 5 to 2 to the interface.
// [RQ14] Interface outputs drive only with direction bit set; inputs always inputs.
// [RQ15] Open drain select makes port pins drive low only.
// [RQ16] Master with direction bit 5 set uses select as output, no fault.
// [RQ17] Collision flag clears after status read then data access.
// [RQ18] Interrupt stays high while an enabled flag stays set.
module spi_error_and_control (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wrData,
  input  wire logic       wrStb,
  input  wire logic       rdStb,
  output logic      [7:0] rdData,
  input  wire logic       condCodeIntMask,
  output logic            irq,
  input  wire logic [3:0] portPinIn,
  output logic      [3:0] portPinOut,
  output logic      [3:0] portPinOe
);
  // ==========================================================
  // State
  typedef struct packed {
    logic [7:0] control;
    logic [3:0] portDir;
    logic [3:0] portData;
    logic       complete;
    logic       collision;
    logic       modeFault;
    logic       completeArm;
    logic       collisionArm;
    logic       modeFaultArm;
    logic [2:0] events;
    logic [2:0] eventMask;
    logic [7:0] rxBuffer;
    logic [7:0] rdData;
    logic [3:0] pinOut;
    logic [3:0] pinOe;
  } ctrl_state_t;

  ctrl_state_t s_q, s_d;

  // ==========================================================
  // Pin synchroniser and shifter
  logic [3:0] pinSync;
  spi_core_if core ();

  pin_sync #(
    .W (4)
  ) u_pin_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .async   (portPinIn),
    .sync    (pinSync)
  );

  spi_shifter u_shifter (
    .ref_clk (ref_clk),
    .rst     (rst),
    .e       (core)
  );

  // ==========================================================
  // Decoded control fields
  logic sysEnable;
  logic masterSel;
  logic openDrain;
  logic irqEnable;
  logic selectLow;

  assign irqEnable = s_q.control[spi_err_pkg::CTL_IRQ_EN];
  assign sysEnable = s_q.control[spi_err_pkg::CTL_SYS_EN];
  assign openDrain = s_q.control[spi_err_pkg::CTL_OPEN_DRN];
  assign masterSel = s_q.control[spi_err_pkg::CTL_MASTER];
  assign selectLow = ~pinSync[spi_err_pkg::PIN_SS];

  // ==========================================================
  // Shifter hookup
  // Slave select only counts in slave mode; in master it feeds fault detection
  assign core.master = masterSel & sysEnable;
  assign core.clock_idle_polarity   = s_q.control[spi_err_pkg::CTL_CLOCK_IDLE_POLARITY];
  assign core.clock_phase_select   = s_q.control[spi_err_pkg::CTL_CLOCK_PHASE_SELECT];
  assign core.rate   = s_q.control[spi_err_pkg::CTL_RATE_HI -: 2];
  assign core.sckIn  = pinSync[spi_err_pkg::PIN_SCK];
  assign core.ssLow  = sysEnable & ~masterSel & selectLow;
  assign core.sdi    = masterSel ? pinSync[spi_err_pkg::PIN_MISO]
                                 : pinSync[spi_err_pkg::PIN_MOSI];
  assign core.txByte = wrData;

  // ==========================================================
  // Register port decode
  logic ctrlWrite;
  logic dataWrite;
  logic dataRead;
  logic statusRead;
  logic dataAccess;

  assign ctrlWrite  = wrStb & (addr == spi_err_pkg::OFS_CONTROL);
  assign dataWrite  = wrStb & (addr == spi_err_pkg::OFS_DATA);
  assign dataRead   = rdStb & (addr == spi_err_pkg::OFS_DATA);
  assign statusRead = rdStb & (addr == spi_err_pkg::OFS_STATUS);
  assign dataAccess = dataWrite | dataRead;

  // ==========================================================
  // Error detection
  logic modeFaultDet;
  logic writeInhibit;
  logic collide;

  // Select pin as an output in master mode hides the fault input [RQ1] [RQ16]
  assign modeFaultDet = sysEnable & masterSel & ~s_q.portDir[spi_err_pkg::PIN_SS]
                        & selectLow;
  // A pending completion must be acknowledged by a status read first
  assign writeInhibit = s_q.complete & ~s_q.completeArm;
  // Any configuration may collide; master writes are checked too [RQ3] [RQ6]
  assign collide      = dataWrite & core.busy & ~writeInhibit;
  // Colliding data never reaches the shifter [RQ4]
  assign core.load    = dataWrite & sysEnable & ~core.busy & ~writeInhibit;

  // ==========================================================
  // Pin steering, one slice per port pin
  logic [3:0] funcDrive;
  logic [3:0] funcValue;
  logic [3:0] pinDrive;
  logic [3:0] pinValue;
  logic [3:0] pinEnable;

  // Which pins the interface would drive: MISO as selected slave, MOSI and SCK
  // as master; select is never driven by the interface itself
  assign funcDrive[spi_err_pkg::PIN_MISO] = sysEnable & ~masterSel & selectLow;
  assign funcDrive[spi_err_pkg::PIN_MOSI] = sysEnable & masterSel;
  assign funcDrive[spi_err_pkg::PIN_SCK]  = sysEnable & masterSel;
  assign funcDrive[spi_err_pkg::PIN_SS]   = 1'b0;
  assign funcValue[spi_err_pkg::PIN_MISO] = core.sdo;
  assign funcValue[spi_err_pkg::PIN_MOSI] = core.sdo;
  assign funcValue[spi_err_pkg::PIN_SCK]  = core.sckOut;
  assign funcValue[spi_err_pkg::PIN_SS]   = 1'b0;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pin
      logic gpioDrive;
      // Disabled: plain port pin; enabled master: select may be a port output
      assign gpioDrive     = s_q.portDir[gi] & (~sysEnable
                             | ((gi == spi_err_pkg::PIN_SS) & masterSel));  // [RQ13] [RQ16]
      // Interface outputs need the direction bit, otherwise they are inputs
      assign pinDrive[gi]  = (funcDrive[gi] & s_q.portDir[gi]) | gpioDrive;  // [RQ14]
      assign pinValue[gi]  = funcDrive[gi] ? funcValue[gi] : s_q.portData[gi];
      // Open drain only pulls low so wired-OR lines cannot fight [RQ15]
      assign pinEnable[gi] = pinDrive[gi] & (~openDrain | ~pinValue[gi]);
    end
  endgenerate

  // ==========================================================
  // Read multiplexer, answered one cycle after the strobe
  logic [7:0] statusWord;
  logic [7:0] readValue;

  always_comb begin
    statusWord = 8'h00;
    statusWord[spi_err_pkg::STS_COMPLETE]  = s_q.complete;
    statusWord[spi_err_pkg::STS_COLLISION] = s_q.collision;
    statusWord[spi_err_pkg::STS_MODE_FLT]  = s_q.modeFault;
  end

  always_comb begin
    readValue = 8'h00;
    case (addr)
      spi_err_pkg::OFS_CONTROL:   readValue = s_q.control;
      spi_err_pkg::OFS_STATUS:    readValue = statusWord;
      spi_err_pkg::OFS_DATA:      readValue = s_q.rxBuffer;
      spi_err_pkg::OFS_EVENT:     readValue = {5'h00, s_q.events};
      spi_err_pkg::OFS_EVT_MASK:  readValue = {5'h00, s_q.eventMask};
      spi_err_pkg::OFS_PORT_DIR:  readValue = {2'h0, s_q.portDir, 2'h0};
      spi_err_pkg::OFS_PORT_DATA: readValue = {2'h0, pinSync, 2'h0};
      default:                    readValue = 8'h00;
    endcase
  end

  // ==========================================================
  // Next state
  always_comb begin
    s_d = s_q;

    // Read data stands only in the cycle after the strobe
    s_d.rdData = rdStb ? readValue : 8'h00;

    // Control register; a fault in the same cycle still drops master [RQ11]
    if (ctrlWrite) s_d.control = wrData;
    if (wrStb && addr == spi_err_pkg::OFS_PORT_DIR) begin
      s_d.portDir = wrData[spi_err_pkg::PORT_LSB +: 4];
    end
    if (wrStb && addr == spi_err_pkg::OFS_PORT_DATA) begin
      s_d.portData = wrData[spi_err_pkg::PORT_LSB +: 4];
    end
    if (wrStb && addr == spi_err_pkg::OFS_EVT_MASK) begin
      s_d.eventMask = wrData[2:0];
    end

    // Fault shuts the drivers off to limit pin contention [RQ2]
    if (modeFaultDet) begin
      s_d.control[spi_err_pkg::CTL_MASTER] = 1'b0;
      s_d.portDir                          = 4'h0;
    end

    // Received byte moves to the read buffer on completion
    if (core.done) s_d.rxBuffer = core.rxByte;

    // Status read while a flag is set arms its clear
    if (statusRead && s_q.complete)  s_d.completeArm  = 1'b1;
    if (statusRead && s_q.collision) s_d.collisionArm = 1'b1;
    if (statusRead && s_q.modeFault) s_d.modeFaultArm = 1'b1;

    // Completion: armed data access clears, a new completion wins
    if (s_q.completeArm && dataAccess) begin
      s_d.complete    = 1'b0;
      s_d.completeArm = 1'b0;
    end
    if (core.done) s_d.complete = 1'b1;

    // Collision: armed data access clears, a new collision wins [RQ17]
    if (s_q.collisionArm && dataAccess) begin
      s_d.collision    = 1'b0;
      s_d.collisionArm = 1'b0;
    end
    if (collide) s_d.collision = 1'b1;  // [RQ3]

    // Mode fault: armed control write clears, a live fault wins
    if (s_q.modeFaultArm && ctrlWrite) begin
      s_d.modeFault    = 1'b0;
      s_d.modeFaultArm = 1'b0;
    end
    if (modeFaultDet) s_d.modeFault = 1'b1;  // [RQ1]

    // Sticky event bits, write one to clear, a new event wins
    if (wrStb && addr == spi_err_pkg::OFS_EVENT) begin
      s_d.events = s_q.events & ~wrData[2:0];
    end
    if (core.done)    s_d.events[spi_err_pkg::EVT_COMPLETE]  = 1'b1;
    if (modeFaultDet) s_d.events[spi_err_pkg::EVT_MODE_FLT]  = 1'b1;
    if (collide)      s_d.events[spi_err_pkg::EVT_COLLISION] = 1'b1;

    // Pins registered so the pads see glitch-free levels
    s_d.pinOut = pinValue;
    s_d.pinOe  = pinEnable;
  end

  // ==========================================================
  // Registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q         <= '0;
      s_q.control <= spi_err_pkg::CONTROL_RESET;  // [RQ11]
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs
  // Level request; the condition-code mask blocks it outright [RQ12] [RQ18]
  assign irq = ~condCodeIntMask
               & ((irqEnable & (s_q.complete | s_q.modeFault))
                  | (|(s_q.events & s_q.eventMask)));
  assign rdData     = s_q.rdData;
  assign portPinOut = s_q.pinOut;
  assign portPinOe  = s_q.pinOe;
endmodule

// ### test/spi_err_monitor.sv
// Checker for the serial error and control block, seeing its top ports only.
// Assumes register shadows may follow the write strobe; bound at the foot.
module spi_err_monitor (
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wrData,
  input wire logic       wrStb,
  input wire logic       rdStb,
  input wire logic [7:0] rdData,
  input wire logic       condCodeIntMask,
  input wire logic       irq,
  input wire logic [3:0] portPinIn,
  input wire logic [3:0] portPinOut,
  input wire logic [3:0] portPinOe
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Shadows of control, direction and latch
  logic [7:0] ctl_q;
  logic [3:0] dir_q;
  logic [3:0] lat_q;
  // Fault clears are not mirrored, so properties lean on the shadows loosely
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctl_q <= spi_err_pkg::CONTROL_RESET;
      dir_q <= 4'h0;
      lat_q <= 4'h0;
    end else if (wrStb) begin
      if (addr == spi_err_pkg::OFS_CONTROL) ctl_q <= wrData;
      if (addr == spi_err_pkg::OFS_PORT_DIR) dir_q <= wrData[5:2];
      if (addr == spi_err_pkg::OFS_PORT_DATA) lat_q <= wrData[5:2];
    end
  end
  // ==========================================
  // Properties
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  sequence ssHeldLow;
    (ctl_q[6] && ctl_q[4] && !dir_q[3] && !portPinIn[3]) [*4];
  endsequence
  sequence selectOwned;
    (ctl_q[6] && ctl_q[4] && !ctl_q[5] && dir_q[3] && dir_q[2]) [*3];
  endsequence
  ctl_readback_a: assert property (
    rdStb && addr == spi_err_pkg::OFS_CONTROL |=> (rdData & 8'hEF) == (ctl_q & 8'hEF))
    else $error("control readback differs from last write");
  irq_mask_a: assert property (condCodeIntMask |-> !irq)
    else $error("interrupt high while masked");
  fault_release_a: assert property (ssHeldLow |-> ##[1:6] portPinOe == 4'h0)
    else $error("drivers kept after mode fault");
  select_output_a: assert property (selectOwned |-> portPinOe[3] && portPinOe[2])
    else $error("select pin not an output in master");
  oe_needs_dir_a: assert property ((portPinOe & ~(dir_q | $past(dir_q))) == 4'h0)
    else $error("pin driven without direction bit");
  open_drain_a: assert property (
    ctl_q[6] && ctl_q[5] && $past(ctl_q[6]) && $past(ctl_q[5])
    |-> (portPinOe & portPinOut) == 4'h0)
    else $error("open drain pin driven high");
  gpio_pins_a: assert property (
    !ctl_q[6] && !$past(ctl_q[6]) && $stable(dir_q) && $stable(lat_q)
    |-> portPinOe == dir_q && (portPinOut & dir_q) == (lat_q & dir_q))
    else $error("port pins not plain outputs while disabled");
  irq_hold_a: assert property (
    $fell(irq) |-> $past(wrStb) || $past(rdStb) || condCodeIntMask)
    else $error("interrupt dropped without software action");
endmodule

bind spi_error_and_control spi_err_monitor mon (
  .ref_clk(ref_clk), .rst(rst), .addr(addr), .wrData(wrData), .wrStb(wrStb),
  .rdStb(rdStb), .rdData(rdData), .condCodeIntMask(condCodeIntMask), .irq(irq),
  .portPinIn(portPinIn), .portPinOut(portPinOut), .portPinOe(portPinOe));

// ### test/spi_far_end.sv
// Far-end model on the four port pins: an outside master or slave.
// Assumes pulled-up lines; its 64 ns link clock stands still between frames.
module spi_far_end (
  input  wire logic [3:0] pinOut,
  input  wire logic [3:0] pinOe,
  output wire logic [3:0] pinIn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       farMaster = 1'b0;
  logic       ss = 1'b1;
  logic       sck = 1'b0;
  logic       mosi = 1'b1;
  logic [7:0] txSh = 8'hFF;
  logic [7:0] rx = 8'h00;
  logic [3:0] drv;
  // Block drive wins; released lines go to their pull-ups
  // As master it drives select, clock and MOSI; as slave, select and MISO
  assign drv = {1'b1, farMaster, farMaster, ~farMaster};
  assign pinIn = (pinOe & pinOut) | (~pinOe & ((drv & {ss, sck, mosi, txSh[7]}) | ~drv));
  // Slave side: capture on rising clock, next bit on falling
  always @(posedge pinIn[2]) begin
    if (!farMaster) rx <= {rx[6:0], pinIn[1]};
  end
  always @(negedge pinIn[2]) begin
    if (!farMaster) txSh <= {txSh[6:0], 1'b1};
  end
  task automatic load(input logic [7:0] b);
    farMaster = 1'b0;
    txSh = b;
    rx = 8'h00;
  endtask
  // Master frame; select is left low so the caller decides when it ends.
  // Clock parks at idle before select falls, so the slave sees no false edge.
  task automatic frame(input logic [7:0] b, input logic clock_phase_select);
    sck = 1'b0;
    farMaster = 1'b1;
    #32;
    ss = 1'b0;
    #32;
    for (int i = 7; i >= 0; i--) begin
      mosi = b[i];
      sck = clock_phase_select;
      #32;
      rx = {rx[6:0], pinIn[0]};  // Slave output taken just before sample edge
      sck = ~clock_phase_select;
      #32;
    end
    sck = 1'b0;
    #32;
  endtask
  task automatic idle();
    ss = 1'b1;
    #64;
    farMaster = 1'b0;
  endtask
endmodule

// ### test/test_spi_error_and_control.sv
// Testbench for the serial error and control block.
// Assumes the far-end model on the pins and the bound checker.
module test_spi_error_and_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic       ref_clk = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wrData = 8'h00;
  logic       wrStb = 1'b0;
  logic       rdStb = 1'b0;
  logic       condCodeIntMask = 1'b0;
  logic [7:0] rdData;
  logic       irq;
  logic [3:0] portPinIn;
  logic [3:0] portPinOut;
  logic [3:0] portPinOe;
  logic [7:0] v;
  int         mismatches = 0;
  int         checked = 0;
  always #2 ref_clk = ~ref_clk;
  spi_error_and_control dut (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wrData(wrData),
    .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .condCodeIntMask(condCodeIntMask),
    .irq(irq), .portPinIn(portPinIn), .portPinOut(portPinOut), .portPinOe(portPinOe));
  spi_far_end far (.pinOut(portPinOut), .pinOe(portPinOe), .pinIn(portPinIn));
  // ==========================================
  // Bus and compare helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wrData <= d;
    wrStb <= 1'b1;
    @(posedge ref_clk);
    wrStb <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge ref_clk);
    rdStb <= 1'b0;
    #1;
    d = rdData;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    rd(a, v);
    chk(v, e);
  endtask
  // Bounded poll; the status read also arms flag clearing
  task automatic waitbit(input logic [7:0] m);
    for (int i = 0; i < 300; i++) begin
      rd(spi_err_pkg::OFS_STATUS, v);
      if ((v & m) != 8'h00) break;
    end
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset();
    rc(spi_err_pkg::OFS_CONTROL, 8'h04);
    chk({3'h0, irq, portPinOe}, 8'h00);
    wr(spi_err_pkg::OFS_CONTROL, 8'h2F);
    rc(spi_err_pkg::OFS_CONTROL, 8'h2F);
    wr(spi_err_pkg::OFS_CONTROL, 8'h00);
    rc(8'h30, 8'h00);
  endtask
  // Master, open drain, slowest rate; second write collides
  task automatic t_master();
    wr(spi_err_pkg::OFS_PORT_DIR, 8'h1C);
    wr(spi_err_pkg::OFS_CONTROL, 8'hF3);
    far.load(8'h96);
    wr(spi_err_pkg::OFS_DATA, 8'hA5);
    wr(spi_err_pkg::OFS_DATA, 8'h3C);
    waitbit(8'h80);
    chk(v, 8'hC0);
    chk({7'h0, irq}, 8'h01);
    @(posedge ref_clk);
    condCodeIntMask <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk({7'h0, irq}, 8'h00);
    @(posedge ref_clk);
    condCodeIntMask <= 1'b0;
    chk(far.rx, 8'hA5);
    rc(spi_err_pkg::OFS_DATA, 8'h96);
    rc(spi_err_pkg::OFS_STATUS, 8'h00);
    chk({7'h0, irq}, 8'h00);
    wr(spi_err_pkg::OFS_EVENT, 8'hFF);
  endtask
  task automatic t_fault();
    wr(spi_err_pkg::OFS_CONTROL, 8'h50);
    @(posedge ref_clk);
    far.ss <= 1'b0;
    repeat (12) @(posedge ref_clk);
    rc(spi_err_pkg::OFS_STATUS, 8'h10);
    rc(spi_err_pkg::OFS_CONTROL, 8'h40);
    rc(spi_err_pkg::OFS_PORT_DIR, 8'h00);
    chk({3'h0, irq, portPinOe}, 8'h00);
    rc(spi_err_pkg::OFS_EVENT, 8'h02);
    wr(spi_err_pkg::OFS_EVT_MASK, 8'h02);
    #1;
    chk({7'h0, irq}, 8'h01);
    wr(spi_err_pkg::OFS_EVENT, 8'h02);
    #1;
    chk({7'h0, irq}, 8'h00);
    wr(spi_err_pkg::OFS_EVT_MASK, 8'h00);
    wr(spi_err_pkg::OFS_PORT_DIR, 8'h00);
    wr(spi_err_pkg::OFS_CONTROL, 8'h00);
  endtask
  // Select low again, but select pin is an output now
  task automatic t_select_out();
    wr(spi_err_pkg::OFS_PORT_DIR, 8'h3C);
    wr(spi_err_pkg::OFS_CONTROL, 8'h50);
    repeat (12) @(posedge ref_clk);
    rc(spi_err_pkg::OFS_STATUS, 8'h00);
    rc(spi_err_pkg::OFS_CONTROL, 8'h50);
    wr(spi_err_pkg::OFS_CONTROL, 8'h00);
    @(posedge ref_clk);
    far.ss <= 1'b1;
  endtask
  task automatic t_slave0();
    wr(spi_err_pkg::OFS_CONTROL, 8'h40);
    // Port pins released by the enable need the sync delay before select reads high
    repeat (4) @(posedge ref_clk);
    wr(spi_err_pkg::OFS_DATA, 8'h5A);
    far.frame(8'h3C, 1'b0);
    repeat (8) @(posedge ref_clk);
    chk({4'h0, portPinOe}, 8'h01);
    chk(far.rx, 8'h5A);
    rc(spi_err_pkg::OFS_STATUS, 8'h80);
    rc(spi_err_pkg::OFS_DATA, 8'h3C);
    wr(spi_err_pkg::OFS_DATA, 8'h11);
    rc(spi_err_pkg::OFS_STATUS, 8'h40);
    rd(spi_err_pkg::OFS_DATA, v);
    rc(spi_err_pkg::OFS_STATUS, 8'h00);
    far.idle();
  endtask
  task automatic t_slave1();
    wr(spi_err_pkg::OFS_CONTROL, 8'h44);
    wr(spi_err_pkg::OFS_DATA, 8'hA6);
    far.frame(8'hC3, 1'b1);
    repeat (8) @(posedge ref_clk);
    chk(far.rx, 8'hA6);
    rc(spi_err_pkg::OFS_STATUS, 8'h80);
    rc(spi_err_pkg::OFS_DATA, 8'hC3);
    wr(spi_err_pkg::OFS_DATA, 8'h22);
    rc(spi_err_pkg::OFS_STATUS, 8'h00);
    far.idle();
  endtask
  task automatic t_gpio();
    wr(spi_err_pkg::OFS_CONTROL, 8'h00);
    wr(spi_err_pkg::OFS_PORT_DATA, 8'h14);
    repeat (4) @(posedge ref_clk);
    #1;
    chk({portPinOe, portPinOut}, 8'hF5);
    rd(spi_err_pkg::OFS_PORT_DATA, v);
    chk(v & 8'h3C, 8'h14);
  endtask
  // ==========================================
  // Verdict, main sequence and watchdog
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_master();
    t_fault();
    t_select_out();
    t_slave0();
    t_slave1();
    t_gpio();
    report_and_stop();
  end
  // Whole run is under a thousand cycles; this limit is fifty thousand
  initial begin
    #200000;
    mismatches++;
    report_and_stop();
  end
endmodule
